// [sio_cfg_pkg.sv]
// constants and carrier types of the resource configuration register group
// assumes a 50 MHz system clock and an isa-style host bus sampled on that clock
package sio_cfg_pkg;

    // register indices behind the data port
    localparam logic [7:0]  IDX_DEF_SELECT   = 8'h16;
    localparam logic [7:0]  IDX_IRQ_PIN_E_A    = 8'h18;
    localparam logic [7:0]  IDX_UART_FAST    = 8'h19;
    localparam logic [7:0]  IDX_FLOPPY_BASE  = 8'h20;
    localparam logic [7:0]  IDX_PAR_BASE     = 8'h23;
    localparam logic [7:0]  IDX_UART_A_BASE  = 8'h24;
    localparam logic [7:0]  IDX_UART_B_BASE  = 8'h25;
    localparam logic [7:0]  IDX_DMA_ALLOC    = 8'h26;
    localparam logic [7:0]  IDX_PAR_IRQ      = 8'h27;

    // host i/o addresses of the index and data ports
    localparam logic [10:0] CFG_INDEX_ADDR   = 11'h3F0;
    localparam logic [10:0] CFG_DATA_ADDR    = 11'h3F1;

    // field positions
    localparam int          DEF_SELECT_BIT   = 2;
    localparam int          FAST_A_BIT       = 1;
    localparam int          FAST_B_BIT       = 0;
    localparam int          ECP_IRQ_LSB      = 5;
    localparam int          DMA_FLOPPY_LSB   = 4;

    // writable bit masks, reserved bits read zero
    localparam logic [7:0]  MASK_UART_FAST   = 8'h03;
    localparam logic [7:0]  MASK_FLOPPY_BASE = 8'hFC;
    localparam logic [7:0]  MASK_UART_BASE   = 8'hFE;
    localparam logic [7:0]  MASK_PAR_IRQ     = 8'hEF;

    // reset values with the default select bit at 1
    localparam logic [7:0]  RST_ZERO         = 8'h00;
    localparam logic [7:0]  RST_FLOPPY_BASE  = 8'hFC;
    localparam logic [7:0]  RST_PAR_BASE     = 8'hDE;
    localparam logic [7:0]  RST_UART_A_BASE  = 8'hFE;
    localparam logic [7:0]  RST_UART_B_BASE  = 8'hBE;
    localparam logic [7:0]  RST_DMA_ALLOC    = 8'h23;
    localparam logic [7:0]  RST_PAR_IRQ      = 8'h05;

    // resource codes
    localparam logic [3:0]  SLOT_NONE        = 4'h0;
    localparam logic [3:0]  SLOT_SMI         = 4'h2;
    localparam logic [3:0]  PIN_SEL_MAX      = 4'h8;

    // sharing-mode request pulse
    localparam int          CLK_PERIOD_NS    = 20;
    localparam int          PIN_E_A_PULSE_NS   = 200;
    localparam logic [3:0]  PIN_E_A_PULSE_CYC  =
        4'((PIN_E_A_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef struct packed {
        logic [10:0] addr;
        logic        aen;
        logic        chip_select_n;
        logic        ior_n;
        logic        iow_n;
        logic [7:0]  data;
    } sio_isa_s;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } sio_irq_pins_s;

    typedef struct packed {
        logic [2:0] floppy;
        logic [2:0] printer;
    } sio_dma_route_s;

endpackage : sio_cfg_pkg

// [sio_cfg_regs.sv]
// resource configuration registers: index/data access, base decode,
// dma routing, parallel-port interrupt routing and uart fast clock selects
// assumes host pins already synchronous to sys_clk_i; the enter/exit
// sequence of extended function mode is decoded elsewhere
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sio_cfg_regs (
    input  wire logic                        sys_clk_i,
    input  wire logic                        nrst_i,
    input  wire sio_cfg_pkg::sio_isa_s       isa_i,
    output logic [7:0]                       isa_data_o,
    output logic                             isa_data_oe_o,
    input  wire logic                        ext_func_mode_i,
    input  wire logic                        default_select_strap_i,
    input  wire logic                        serial_irq_mode_bit_i,
    input  wire logic                        par_epp_en_i,
    input  wire logic                        par_ecp_mode_i,
    input  wire logic                        par_irq_req_i,
    output logic                             floppy_sel_o,
    output logic                             par_sel_o,
    output logic                             uart_a_sel_o,
    output logic                             uart_b_sel_o,
    output logic                             fast_clk_first_uart_o,
    output logic                             fast_clk_second_uart_o,
    output sio_cfg_pkg::sio_dma_route_s      dma_route_o,
    output logic [2:0]                       ecp_irq_number_o,
    output sio_cfg_pkg::sio_irq_pins_s       irq_pins_o,
    output logic [3:0]                       serial_irq_slot_o,
    output logic                             serial_irq_pin_req_o
);
    import sio_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state

    // host access state
    logic [7:0] index_r;
    logic [7:0] index_nxt;
    logic       default_select_bit_r;
    logic       default_select_bit_nxt;
    logic       init_done_r;
    logic       init_done_nxt;

    // resource registers
    logic [7:0] irq_pin_e_a_mode_r;
    logic [7:0] irq_pin_e_a_mode_nxt;
    logic [7:0] uart_fast_clock_r;
    logic [7:0] uart_fast_clock_nxt;
    logic [7:0] floppy_base_addr_r;
    logic [7:0] floppy_base_addr_nxt;
    logic [7:0] parallel_base_addr_r;
    logic [7:0] parallel_base_addr_nxt;
    logic [7:0] serial_a_base_addr_r;
    logic [7:0] serial_a_base_addr_nxt;
    logic [7:0] serial_b_base_addr_r;
    logic [7:0] serial_b_base_addr_nxt;
    logic [7:0] dma_channel_alloc_r;
    logic [7:0] dma_channel_alloc_nxt;
    logic [7:0] parallel_irq_alloc_r;
    logic [7:0] parallel_irq_alloc_nxt;

    // write edge and read data
    logic       iow_n_prev_r;
    logic       iow_n_prev_nxt;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;

    // combinational decode
    logic       wr_stb;
    logic       hit_index;
    logic       hit_data;
    logic       load_defaults;
    logic       load_sel;
    logic [7:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // host port decode

    // write taken once, on the cycle iow_n is first seen low
    assign wr_stb    = ~isa_i.iow_n & iow_n_prev_r;
    assign hit_index = ~isa_i.aen & (isa_i.addr == CFG_INDEX_ADDR);
    assign hit_data  = ~isa_i.aen & (isa_i.addr == CFG_DATA_ADDR);

    // unknown indices read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (index_r)
            IDX_DEF_SELECT:  rd_mux = {5'h00, default_select_bit_r, 2'h0};
            IDX_IRQ_PIN_E_A:   rd_mux = irq_pin_e_a_mode_r;
            IDX_UART_FAST:   rd_mux = uart_fast_clock_r;
            IDX_FLOPPY_BASE: rd_mux = floppy_base_addr_r;
            IDX_PAR_BASE:    rd_mux = parallel_base_addr_r;
            IDX_UART_A_BASE: rd_mux = serial_a_base_addr_r;
            IDX_UART_B_BASE: rd_mux = serial_b_base_addr_r;
            IDX_DMA_ALLOC:   rd_mux = dma_channel_alloc_r;
            IDX_PAR_IRQ:     rd_mux = parallel_irq_alloc_r;
            default:         rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // register next values

    always_comb begin
        index_nxt              = index_r;
        default_select_bit_nxt = default_select_bit_r;
        init_done_nxt          = 1'b1;
        irq_pin_e_a_mode_nxt     = irq_pin_e_a_mode_r;
        uart_fast_clock_nxt    = uart_fast_clock_r;
        floppy_base_addr_nxt   = floppy_base_addr_r;
        parallel_base_addr_nxt = parallel_base_addr_r;
        serial_a_base_addr_nxt = serial_a_base_addr_r;
        serial_b_base_addr_nxt = serial_b_base_addr_r;
        dma_channel_alloc_nxt  = dma_channel_alloc_r;
        parallel_irq_alloc_nxt = parallel_irq_alloc_r;
        iow_n_prev_nxt         = isa_i.iow_n;

        // reload control
        load_defaults          = 1'b0;
        load_sel               = default_select_bit_r;

        if (!init_done_r) begin
            // strap caught on the first edge after reset release
            default_select_bit_nxt = default_select_strap_i;
            load_defaults          = 1'b1;
            load_sel               = default_select_strap_i;
        end else if (wr_stb && ext_func_mode_i && hit_index) begin
            index_nxt = isa_i.data;
        end else if (wr_stb && ext_func_mode_i && hit_data) begin
            unique case (index_r)
                IDX_DEF_SELECT: begin
                    // only a flip reloads, so zeros need a 1 then 0 sequence
                    if (isa_i.data[DEF_SELECT_BIT] != default_select_bit_r) begin
                        default_select_bit_nxt = isa_i.data[DEF_SELECT_BIT];
                        load_defaults          = 1'b1;
                        load_sel               = isa_i.data[DEF_SELECT_BIT];
                    end
                end
                IDX_IRQ_PIN_E_A:   irq_pin_e_a_mode_nxt = isa_i.data;
                IDX_UART_FAST:   uart_fast_clock_nxt = isa_i.data & MASK_UART_FAST;
                IDX_FLOPPY_BASE: floppy_base_addr_nxt =
                    isa_i.data & MASK_FLOPPY_BASE;
                IDX_PAR_BASE:    parallel_base_addr_nxt = isa_i.data;
                IDX_UART_A_BASE: serial_a_base_addr_nxt =
                    isa_i.data & MASK_UART_BASE;
                IDX_UART_B_BASE: serial_b_base_addr_nxt =
                    isa_i.data & MASK_UART_BASE;
                IDX_DMA_ALLOC:   dma_channel_alloc_nxt = isa_i.data;
                IDX_PAR_IRQ:     parallel_irq_alloc_nxt = isa_i.data & MASK_PAR_IRQ;
                default: begin
                end
            endcase
        end

        // reload spares pin_e_a and fast clock
        if (load_defaults) begin
            floppy_base_addr_nxt   = load_sel ? RST_FLOPPY_BASE : RST_ZERO;
            parallel_base_addr_nxt = load_sel ? RST_PAR_BASE    : RST_ZERO;
            serial_a_base_addr_nxt = load_sel ? RST_UART_A_BASE : RST_ZERO;
            serial_b_base_addr_nxt = load_sel ? RST_UART_B_BASE : RST_ZERO;
            dma_channel_alloc_nxt  = load_sel ? RST_DMA_ALLOC   : RST_ZERO;
            parallel_irq_alloc_nxt = load_sel ? RST_PAR_IRQ     : RST_ZERO;
        end

        // read data registered: valid from the cycle after ior_n falls
        rd_data_nxt = 8'h00;
        if (ext_func_mode_i && hit_index) begin
            rd_data_nxt = index_r;
        end else if (ext_func_mode_i && hit_data) begin
            rd_data_nxt = rd_mux;
        end
    end

    // registers only
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            index_r              <= 8'h00;
            default_select_bit_r <= 1'b0;
            init_done_r          <= 1'b0;
            irq_pin_e_a_mode_r     <= RST_ZERO;
            uart_fast_clock_r    <= RST_ZERO;
            floppy_base_addr_r   <= RST_ZERO;
            parallel_base_addr_r <= RST_ZERO;
            serial_a_base_addr_r <= RST_ZERO;
            serial_b_base_addr_r <= RST_ZERO;
            dma_channel_alloc_r  <= RST_ZERO;
            parallel_irq_alloc_r <= RST_ZERO;
            iow_n_prev_r         <= 1'b1;
            rd_data_r            <= 8'h00;
        end else begin
            index_r              <= index_nxt;
            default_select_bit_r <= default_select_bit_nxt;
            init_done_r          <= init_done_nxt;
            irq_pin_e_a_mode_r     <= irq_pin_e_a_mode_nxt;
            uart_fast_clock_r    <= uart_fast_clock_nxt;
            floppy_base_addr_r   <= floppy_base_addr_nxt;
            parallel_base_addr_r <= parallel_base_addr_nxt;
            serial_a_base_addr_r <= serial_a_base_addr_nxt;
            serial_b_base_addr_r <= serial_b_base_addr_nxt;
            dma_channel_alloc_r  <= dma_channel_alloc_nxt;
            parallel_irq_alloc_r <= parallel_irq_alloc_nxt;
            iow_n_prev_r         <= iow_n_prev_nxt;
            rd_data_r            <= rd_data_nxt;
        end
    end

    // bus driven only on config reads
    assign isa_data_o    = rd_data_r;
    assign isa_data_oe_o = ~isa_i.ior_n & ext_func_mode_i & (hit_index | hit_data);

    ////////////////////////////////////////////////////////////////////////////
    // function address decode

    logic qual_low;
    logic floppy_en;
    logic par_en;
    logic uart_a_en;
    logic uart_b_en;
    logic par_match;

    // config ports skip chip select
    assign qual_low  = ~isa_i.chip_select_n & ~isa_i.aen;

    // bits 7 and 6 clear: window off
    assign floppy_en = |floppy_base_addr_r[7:6];
    assign par_en    = |parallel_base_addr_r[7:6];
    assign uart_a_en = |serial_a_base_addr_r[7:6];
    assign uart_b_en = |serial_b_base_addr_r[7:6];

    // epp drops A2 from the compare
    always_comb begin
        if (par_epp_en_i) begin
            par_match = (isa_i.addr[9:3] == parallel_base_addr_r[7:1]);
        end else begin
            par_match = (isa_i.addr[9:2] == parallel_base_addr_r);
        end
    end

    // no wait states: selects follow the address pins in the same cycle
    assign floppy_sel_o = qual_low & ~isa_i.addr[10] & floppy_en
                        & (isa_i.addr[9:4] == floppy_base_addr_r[7:2])
                        & ~isa_i.addr[3];

    // ecp mode reaches its second register bank at base plus 400h
    assign par_sel_o    = qual_low & par_en & par_match
                        & (par_ecp_mode_i | ~isa_i.addr[10]);

    // uart windows: A2..A0 free
    assign uart_a_sel_o = qual_low & ~isa_i.addr[10] & uart_a_en
                        & (isa_i.addr[9:3] == serial_a_base_addr_r[7:1]);
    assign uart_b_sel_o = qual_low & ~isa_i.addr[10] & uart_b_en
                        & (isa_i.addr[9:3] == serial_b_base_addr_r[7:1]);

    ////////////////////////////////////////////////////////////////////////////
    // clock selects and dma routing

    // clock muxes sit in the uarts
    assign fast_clk_first_uart_o  = uart_fast_clock_r[FAST_A_BIT];
    assign fast_clk_second_uart_o = uart_fast_clock_r[FAST_B_BIT];

    // upper nibble floppy
    logic [3:0] floppy_dma_sel;
    logic [3:0] printer_dma_sel;

    assign floppy_dma_sel  = dma_channel_alloc_r[DMA_FLOPPY_LSB +: 4];
    assign printer_dma_sel = dma_channel_alloc_r[3:0];

    // one-hot channel A..C; codes above 3 route nowhere
    always_comb begin
        dma_route_o = '0;
        for (int ch = 0; ch < 3; ch++) begin
            dma_route_o.floppy[ch]  = (floppy_dma_sel == 4'(ch + 1));
            dma_route_o.printer[ch] = (printer_dma_sel == 4'(ch + 1));
        end
    end

    // software must keep this consistent with the pin routing below
    assign ecp_irq_number_o = parallel_irq_alloc_r[ECP_IRQ_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////////
    // parallel-port interrupt routing

    logic [3:0] printer_irq_sel;
    logic       pin_valid;
    logic [2:0] pin_idx;
    logic       irq_prev_r;
    logic       irq_prev_nxt;
    logic [3:0] pin_e_a_cnt_r;
    logic [3:0] pin_e_a_cnt_nxt;
    logic       irq_rise;

    // codes 9..15 pick no pin
    assign printer_irq_sel = parallel_irq_alloc_r[3:0];
    assign pin_valid       = (printer_irq_sel != 4'h0)
                           & (printer_irq_sel <= PIN_SEL_MAX)
                           & ~serial_irq_mode_bit_i;
    assign pin_idx         = 3'(printer_irq_sel - 4'h1);
    assign irq_rise        = par_irq_req_i & ~irq_prev_r;

    // ten 20 ns cycles give 200 ns
    always_comb begin
        irq_prev_nxt  = par_irq_req_i;
        pin_e_a_cnt_nxt = pin_e_a_cnt_r;
        if (pin_e_a_cnt_r != 4'h0) begin
            pin_e_a_cnt_nxt = pin_e_a_cnt_r - 4'h1;
        end
        // a new edge restarts the low pulse on the selected sharing pin
        if (irq_rise && pin_valid && irq_pin_e_a_mode_r[pin_idx]) begin
            pin_e_a_cnt_nxt = PIN_E_A_PULSE_CYC;
        end
    end

    // idle-low reset: no false edge
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_prev_r  <= 1'b0;
            pin_e_a_cnt_r <= 4'h0;
        end else begin
            irq_prev_r  <= irq_prev_nxt;
            pin_e_a_cnt_r <= pin_e_a_cnt_nxt;
        end
    end

    // sharing pins only pull low
    for (genvar p = 0; p < 8; p++) begin : g_irq_pin
        logic selected;
        assign selected = pin_valid & (pin_idx == 3'(p));
        always_comb begin
            if (irq_pin_e_a_mode_r[p]) begin
                irq_pins_o.out[p] = 1'b0;
                irq_pins_o.oe[p]  = selected & (pin_e_a_cnt_r != 4'h0);
            end else begin
                irq_pins_o.out[p] = par_irq_req_i;
                irq_pins_o.oe[p]  = selected;
            end
        end
    end

    // framing of the serial interrupt stream is handled by its own block
    assign serial_irq_slot_o    = serial_irq_mode_bit_i ? printer_irq_sel
                                                        : SLOT_NONE;
    assign serial_irq_pin_req_o = serial_irq_mode_bit_i & par_irq_req_i
                                & (printer_irq_sel != SLOT_NONE)
                                & (printer_irq_sel != SLOT_SMI);

endmodule : sio_cfg_regs

// [sio_cfg_regs_checker.sv]
// port-level assertions for the resource configuration registers
// bound into sio_cfg_regs; single clock domain, async low reset
`timescale 1ns/1ps
module sio_cfg_regs_checker (
    input wire logic                        sys_clk_i,
    input wire logic                        nrst_i,
    input wire sio_cfg_pkg::sio_isa_s       isa_i,
    input wire logic                        isa_data_oe_o,
    input wire logic                        ext_func_mode_i,
    input wire logic                        serial_irq_mode_bit_i,
    input wire logic                        par_ecp_mode_i,
    input wire logic                        par_irq_req_i,
    input wire logic                        floppy_sel_o,
    input wire logic                        par_sel_o,
    input wire logic                        uart_a_sel_o,
    input wire logic                        uart_b_sel_o,
    input wire sio_cfg_pkg::sio_dma_route_s dma_route_o,
    input wire sio_cfg_pkg::sio_irq_pins_s  irq_pins_o,
    input wire logic [3:0]                  serial_irq_slot_o,
    input wire logic                        serial_irq_pin_req_o
);
    import sio_cfg_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic ok = !isa_i.chip_select_n && !isa_i.aen;
    wire logic a10 = isa_i.addr[10];
    wire logic cfg = isa_i.addr == CFG_INDEX_ADDR || isa_i.addr == CFG_DATA_ADDR;

    floppy_dec_a: assert property (floppy_sel_o |-> ok && !a10 && !isa_i.addr[3])
        else $error("floppy select outside its window");
    par_dec_a: assert property (par_sel_o |-> ok && (par_ecp_mode_i || !a10))
        else $error("parallel select without qualifiers");
    uart_a_dec_a: assert property (uart_a_sel_o |-> ok && !a10)
        else $error("first uart select without qualifiers");
    uart_b_dec_a: assert property (uart_b_sel_o |-> ok && !a10)
        else $error("second uart select without qualifiers");
    read_oe_a: assert property (isa_data_oe_o == (!isa_i.ior_n && !isa_i.aen
        && ext_func_mode_i && cfg)) else $error("read enable wrong");
    serial_tri_a: assert property (serial_irq_mode_bit_i |-> irq_pins_o.oe == 8'h00)
        else $error("pin driven in serial mode");
    serial_req_a: assert property (serial_irq_pin_req_o |-> serial_irq_mode_bit_i
        && par_irq_req_i && serial_irq_slot_o != SLOT_NONE && serial_irq_slot_o != SLOT_SMI)
        else $error("serial request in bad slot");
    slot_idle_a: assert property (!serial_irq_mode_bit_i |-> serial_irq_slot_o == 4'h0)
        else $error("slot shown outside serial mode");
    dma_onehot_a: assert property ($onehot0(dma_route_o.floppy)
        && $onehot0(dma_route_o.printer)) else $error("two dma channels at once");
    pin_onehot_a: assert property ($onehot0(irq_pins_o.oe))
        else $error("more than one interrupt pin driven");

    floppy_hit_c: cover property (floppy_sel_o);
    serial_req_c: cover property (serial_irq_pin_req_o);
    pin_drive_c: cover property (|irq_pins_o.oe);
endmodule : sio_cfg_regs_checker

bind sio_cfg_regs sio_cfg_regs_checker sio_cfg_regs_checker_i (.*);

// [sio_isa_host.sv]
// isa host model: index/data port cycles and address probes
// assumes one bench clock; pins change just after the falling edge
`timescale 1ns/1ps
module sio_isa_host (
    input  wire logic             sys_clk_i,
    output sio_cfg_pkg::sio_isa_s isa_o,
    output logic                  rd_stb_o,
    output logic                  pr_stb_o
);
    import sio_cfg_pkg::*;
    logic aen_v = 1'b0;
    initial begin
        isa_o = {11'h000, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
        rd_stb_o = 1'b0;
        pr_stb_o = 1'b0;
    end
    // strobe stays high a full cycle so the next write sees an edge
    task automatic port_wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        isa_o.addr = a;
        isa_o.aen = aen_v;
        isa_o.data = d;
        isa_o.iow_n = 1'b0;
        @(negedge sys_clk_i);
        isa_o.iow_n = 1'b1;
        isa_o.data = ~d;
    endtask : port_wr
    task automatic cfg_wr(input logic [7:0] i, input logic [7:0] v);
        port_wr(CFG_INDEX_ADDR, i);
        port_wr(CFG_DATA_ADDR, v);
    endtask : cfg_wr
    task automatic cfg_rd(input logic [7:0] i);
        port_wr(CFG_INDEX_ADDR, i);
        @(negedge sys_clk_i);
        isa_o.addr = CFG_DATA_ADDR;
        isa_o.ior_n = 1'b0;
        @(negedge sys_clk_i);
        rd_stb_o = 1'b1;
        @(negedge sys_clk_i);
        rd_stb_o = 1'b0;
        isa_o.ior_n = 1'b1;
    endtask : cfg_rd
    task automatic probe(input logic [10:0] a, input logic cs_n);
        @(negedge sys_clk_i);
        isa_o.addr = a;
        isa_o.aen = 1'b0;
        isa_o.chip_select_n = cs_n;
        pr_stb_o = 1'b1;
        @(negedge sys_clk_i);
        pr_stb_o = 1'b0;
        isa_o.chip_select_n = 1'b1;
    endtask : probe
endmodule : sio_isa_host

// [sio_cfg_regs_tb.sv]
// self-checking bench for the resource configuration registers
// assumes the isa host model drives all bus pins
`timescale 1ns/1ps
module sio_cfg_regs_tb;
    import sio_cfg_pkg::*;
    localparam logic [7:0] IDX [8] = '{IDX_IRQ_PIN_E_A, IDX_UART_FAST, IDX_FLOPPY_BASE,
        IDX_PAR_BASE, IDX_UART_A_BASE, IDX_UART_B_BASE, IDX_DMA_ALLOC, IDX_PAR_IRQ};
    localparam logic [7:0] DEF [8] = '{8'h00, 8'h00, 8'hFC, 8'hDE, 8'hFE, 8'hBE, 8'h23, 8'h05};
    localparam logic [7:0] MSK [8] = '{8'hFF, 8'h03, 8'hFC, 8'hFF, 8'hFE, 8'hFE, 8'hFF, 8'hEF};
    logic           clk, nrst, ext, strap, smode, epp, ecp, preq, cs;
    logic           oe, fsel, psel, asel, bsel, fa, fb, spreq, rd_stb, pr_stb;
    logic [7:0]     rdat, e, bs [4];
    logic [10:0]    a;
    logic [2:0]     ecpn;
    logic [3:0]     slot;
    sio_isa_s       isa;
    sio_irq_pins_s  pins;
    sio_dma_route_s dma;
    logic [7:0]     q [$];
    int             mismatches, n_compared, n;

    sio_isa_host sio_isa_host_i (.sys_clk_i(clk), .isa_o(isa), .rd_stb_o(rd_stb),
        .pr_stb_o(pr_stb));
    sio_cfg_regs sio_cfg_regs_i (.sys_clk_i(clk), .nrst_i(nrst), .isa_i(isa),
        .isa_data_o(rdat), .isa_data_oe_o(oe), .ext_func_mode_i(ext),
        .default_select_strap_i(strap), .serial_irq_mode_bit_i(smode), .par_epp_en_i(epp),
        .par_ecp_mode_i(ecp), .par_irq_req_i(preq), .floppy_sel_o(fsel), .par_sel_o(psel),
        .uart_a_sel_o(asel), .uart_b_sel_o(bsel), .fast_clk_first_uart_o(fa),
        .fast_clk_second_uart_o(fb), .dma_route_o(dma), .ecp_irq_number_o(ecpn),
        .irq_pins_o(pins), .serial_irq_slot_o(slot), .serial_irq_pin_req_o(spreq));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] s, input logic [7:0] x);
        n_compared++;
        if (s !== x) begin
            mismatches++;
            $display("ERROR t=%0t seen %h expected %h", $time, s, x);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic rd(input logic [7:0] i, input logic [7:0] x);
        q.push_back(x);
        sio_isa_host_i.cfg_rd(i);
    endtask : rd
    task automatic do_reset(input logic s);
        nrst = 1'b0;
        strap = s;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
    endtask : do_reset
    function automatic logic [2:0] oh(input int c);
        return (c == 0) ? 3'b000 : 3'b001 << (c - 1);
    endfunction : oh
    function automatic logic [7:0] sels(input logic [10:0] x, input logic c);
        logic g;
        g = !c && !x[10];
        sels = 8'h00;
        sels[3] = g && bs[0][7:6] != 2'b00 && x[9:4] == bs[0][7:2] && !x[3];
        sels[2] = !c && (ecp || !x[10]) && bs[1][7:6] != 2'b00
            && (epp ? x[9:3] == bs[1][7:1] : x[9:2] == bs[1]);
        sels[1] = g && bs[2][7:6] != 2'b00 && x[9:3] == bs[2][7:1];
        sels[0] = g && bs[3][7:6] != 2'b00 && x[9:3] == bs[3][7:1];
    endfunction : sels

    always @(posedge clk) begin
        if (rd_stb) check(rdat, q.pop_front());
        if (pr_stb) check({4'h0, fsel, psel, asel, bsel}, q.pop_front());
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // about 600 cycles of tests; generous margin
    initial begin
        #(20 * 20000);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        {ext, smode, epp, ecp, preq} = 5'b10000;
        void'($urandom(32'hFEE5));
        do_reset(1'b1);
        for (int i = 0; i < 8; i++) rd(IDX[i], DEF[i]);
        check({2'b00, dma}, 8'h14);
        for (int i = 0; i < 8; i++) begin
            sio_isa_host_i.cfg_wr(IDX[i], 8'hFF);
            rd(IDX[i], MSK[i]);
        end
        sio_isa_host_i.cfg_wr(IDX_FLOPPY_BASE, 8'h40);
        sio_isa_host_i.cfg_wr(IDX_DEF_SELECT, 8'h04);
        rd(IDX_FLOPPY_BASE, 8'h40);
        sio_isa_host_i.cfg_wr(IDX_DEF_SELECT, 8'h00);
        rd(IDX_FLOPPY_BASE, 8'h00);
        sio_isa_host_i.cfg_wr(IDX_DEF_SELECT, 8'h04);
        rd(IDX_UART_B_BASE, 8'hBE);
        for (int c = 0; c < 4; c++) begin
            sio_isa_host_i.cfg_wr(IDX_DMA_ALLOC, {4'(c), 4'(3 - c)});
            check({2'b00, dma}, {2'b00, oh(c), oh(3 - c)});
            sio_isa_host_i.cfg_wr(IDX_UART_FAST, 8'(c));
            check({6'h00, fa, fb}, 8'(c));
        end
        ext = 1'b0;
        sio_isa_host_i.cfg_wr(IDX_UART_FAST, 8'h00);
        ext = 1'b1;
        sio_isa_host_i.aen_v = 1'b1;
        sio_isa_host_i.cfg_wr(IDX_UART_FAST, 8'h00);
        sio_isa_host_i.aen_v = 1'b0;
        rd(IDX_UART_FAST, 8'h03);
        rd(8'h30, 8'h00);
        repeat (6) begin
            {epp, ecp} = 2'($urandom);
            for (int k = 0; k < 4; k++) begin
                bs[k] = 8'($urandom) & MSK[k + 2];
                sio_isa_host_i.cfg_wr(IDX[k + 2], bs[k]);
            end
            repeat (12) begin
                a = {1'($urandom), bs[$urandom % 4], 2'($urandom)};
                cs = ($urandom % 4) == 0;
                q.push_back(sels(a, cs));
                sio_isa_host_i.probe(a, cs);
            end
        end
        sio_isa_host_i.cfg_wr(IDX_IRQ_PIN_E_A, 8'h00);
        preq = 1'b1;
        for (int c = 0; c < 9; c++) begin
            sio_isa_host_i.cfg_wr(IDX_PAR_IRQ, {3'(c), 1'b0, 4'(c)});
            e = (c == 0) ? 8'h00 : 8'h01 << (c - 1);
            check(pins.oe, e);
            check(pins.out & pins.oe, e);
            check({5'h00, ecpn}, 8'(c % 8));
        end
        preq = 1'b0;
        sio_isa_host_i.cfg_wr(IDX_PAR_IRQ, 8'h25);
        sio_isa_host_i.cfg_wr(IDX_IRQ_PIN_E_A, 8'h10);
        preq = 1'b1;
        n = 0;
        repeat (30) begin
            @(negedge clk);
            if (pins.oe[4] === 1'b1 && pins.out[4] === 1'b0) n++;
        end
        check(8'(n), 8'(PIN_E_A_PULSE_CYC));
        check(pins.oe, 8'h00);
        smode = 1'b1;
        for (int c = 0; c < 16; c++) begin
            sio_isa_host_i.cfg_wr(IDX_PAR_IRQ, 8'(c));
            check(pins.oe, 8'h00);
            check({3'b000, spreq, slot}, {3'b000, c != 0 && c != 2, 4'(c)});
        end
        do_reset(1'b0);
        rd(IDX_PAR_BASE, 8'h00);
        tally_and_finish();
    end
endmodule : sio_cfg_regs_tb
